/* verilog/scp_pkg.sv */
// constants, types and decode helpers for the scanner command parser
package scp_pkg;

    // ascii command letters and argument characters
    localparam logic [7:0] CH_RESET = 8'h52;
    localparam logic [7:0] CH_SET_TIME = 8'h53;
    localparam logic [7:0] CH_ALARM = 8'h51;
    localparam logic [7:0] CH_TRIGGER = 8'h54;
    localparam logic [7:0] CH_DATE = 8'h56;
    localparam logic [7:0] CH_INTERVAL = 8'h57;
    localparam logic [7:0] CH_DISPLAY = 8'h44;
    localparam logic [7:0] CH_TERM = 8'h59;
    localparam logic [7:0] CH_DIO = 8'h4f;
    localparam logic [7:0] CH_PROGRAM = 8'h50;
    localparam logic [7:0] CH_EXECUTE = 8'h58;
    localparam logic [7:0] CH_DOT = 8'h2e;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_Z = 8'h5a;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FIRST = 8'h04;
    localparam logic [7:0] OFS_LAST = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_TIME = 8'h10;
    localparam logic [7:0] OFS_ALARM = 8'h14;
    localparam logic [7:0] OFS_DATE = 8'h18;
    localparam logic [7:0] OFS_INTV = 8'h1c;
    localparam logic [7:0] OFS_CHAN = 8'h20;

    // field positions
    localparam int CTRL_INTL_BIT = 0;
    localparam int STAT_ERR_BIT = 0;

    // reset values
    localparam logic [7:0] FIRST_RST = 8'h01;
    localparam logic [7:0] LAST_RST = 8'h0a;
    localparam logic [2:0] TRIG_RST = 3'h0;
    localparam logic [1:0] PROG_RST = 2'h2;
    localparam logic [3:0] TERM_RST = 4'h0;

    // modes and codes
    localparam logic [1:0] PROG_STEP = 2'h0;
    localparam logic [1:0] PROG_MAX = 2'h2;
    localparam logic [3:0] DISP_CHANNEL = 4'h0;
    localparam logic [3:0] SHOW_INTERVAL_DISPLAY_CODE = 4'h1;
    localparam logic [3:0] SHOW_TIME_DISPLAY_CODE = 4'h2;
    localparam logic [1:0] STIM_TALK = 2'h0;
    localparam logic [1:0] STIM_GET = 2'h1;
    localparam logic [1:0] STIM_EXEC = 2'h2;
    localparam logic [1:0] STIM_EXT = 2'h3;
    localparam logic [3:0] TRIG_MAX = 4'h7;

    // command buffer
    localparam int BUF_DEPTH = 32;
    localparam int BUF_AW = 5;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_APPLY = 4'b0100,
        ST_DONE = 4'b1000
    } scp_state_t;

    function automatic logic scp_is_digit(input logic [7:0] c);
        return (c >= CH_ZERO) && (c <= CH_NINE);
    endfunction

    function automatic logic scp_is_letter(input logic [7:0] c);
        return (c >= CH_A) && (c <= CH_Z);
    endfunction

endpackage

/* verilog/scp_sync2.sv */
// two-flop synchroniser for a pin input
`timescale 1ns/10ps
module scp_sync2 import scp_pkg::*; (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic pin_in,
    output logic pin_sync
);
    logic stage1;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            stage1 <= pin_in;
            pin_sync <= stage1;
        end
    end
endmodule

/* verilog/scp_arg_collect.sv */
// gathers the digits of one command argument
`timescale 1ns/10ps
module scp_arg_collect import scp_pkg::*; (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clr,
    input wire logic feed,
    input wire logic [7:0] ch,
    output logic [23:0] int_dig,
    output logic [11:0] frac_dig,
    output logic [2:0] dig_cnt
);
    logic seen_dot;
    logic [1:0] frac_cnt;

    // integer digits shift in from the right, colons are skipped
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            int_dig <= 24'h0;
            frac_dig <= 12'h0;
            dig_cnt <= 3'h0;
            seen_dot <= 1'b0;
            frac_cnt <= 2'h0;
        end else if (clr) begin
            int_dig <= 24'h0;
            frac_dig <= 12'h0;
            dig_cnt <= 3'h0;
            seen_dot <= 1'b0;
            frac_cnt <= 2'h0;
        end else if (feed) begin
            if (ch == CH_DOT) begin
                seen_dot <= 1'b1;
            end else if (scp_is_digit(ch)) begin
                if (dig_cnt != 3'h7) begin
                    dig_cnt <= dig_cnt + 3'h1;
                end
                if (!seen_dot) begin
                    int_dig <= {int_dig[19:0], ch[3:0]};
                end else begin
                    case (frac_cnt)
                        2'h0: frac_dig[11:8] <= ch[3:0];
                        2'h1: frac_dig[7:4] <= ch[3:0];
                        2'h2: frac_dig[3:0] <= ch[3:0];
                        default: ;
                    endcase
                    if (frac_cnt != 2'h3) begin
                        frac_cnt <= frac_cnt + 2'h1;
                    end
                end
            end
        end
    end
endmodule

/* verilog/scp_parser.sv */
// scanner command parser and executor
`timescale 1ns/10ps
module scp_parser import scp_pkg::*; (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic talk_addr,
    input wire logic get_msg,
    input wire logic dev_clear,
    input wire logic ext_trig,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    output logic illegal_option_error,
    output logic [3:0] disp_code,
    output logic [23:0] disp_value,
    output logic [7:0] cur_channel,
    output logic relay_closed,
    output logic scan_running,
    output logic [7:0] dio_out,
    output logic [3:0] term_code
);
    // ==========================================
    // state
    scp_state_t state;
    logic [7:0] cmd_buf [0:BUF_DEPTH-1];
    logic [BUF_AW:0] wr_cnt;
    logic [BUF_AW:0] rd_ptr;
    logic [7:0] cmd;
    logic cmd_pend;
    logic [7:0] next_cmd;
    logic next_pend;
    logic [7:0] cur_ch;
    logic ctrl_intl;
    logic [7:0] first_ch;
    logic [7:0] last_ch;
    logic [23:0] time_bcd;
    logic [23:0] alarm_bcd;
    logic [7:0] date_month;
    logic [7:0] date_day;
    logic [11:0] intv_int;
    logic [11:0] intv_frac;
    logic [2:0] trig_mode;
    logic [1:0] prog_mode;
    logic [23:0] int_dig;
    logic [11:0] frac_dig;
    logic [2:0] dig_cnt;
    logic ext_sync;
    logic ext_prev;

    // ==========================================
    // decode
    logic at_end;
    logic is_ltr;
    logic arg_clr;
    logic arg_feed;
    logic applying;
    logic apply_err;
    logic stim;
    logic stat_clr;

    assign cur_ch = cmd_buf[rd_ptr[BUF_AW-1:0]];
    assign at_end = (rd_ptr == wr_cnt);
    assign is_ltr = scp_is_letter(cur_ch);
    assign applying = (state == ST_APPLY);
    assign arg_clr = applying || (state == ST_FETCH && !at_end && is_ltr && !cmd_pend);
    assign arg_feed = (state == ST_FETCH) && !at_end && !is_ltr && cmd_pend;
    assign stat_clr = wr_en && (addr == OFS_STAT) && wdata[STAT_ERR_BIT];

    always_comb begin
        apply_err = 1'b0;
        if (applying) begin
            case (cmd)
                CH_TRIGGER: apply_err = (dig_cnt != 3'h1) || (int_dig[3:0] > TRIG_MAX);
                CH_DATE: apply_err = (dig_cnt <= 3'h2);
                CH_PROGRAM: apply_err = (dig_cnt != 3'h1) || (int_dig[3:0] > {2'h0, PROG_MAX});
                default: apply_err = 1'b0;
            endcase
        end
    end

    // stimulus chosen by the pair bits of the trigger mode
    always_comb begin
        case (trig_mode[2:1])
            STIM_TALK: stim = talk_addr;
            STIM_GET: stim = get_msg;
            STIM_EXEC: stim = (state == ST_DONE);
            STIM_EXT: stim = ext_sync && !ext_prev;
            default: stim = 1'b0;
        endcase
    end

    scp_sync2 u_ext_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pin_in(ext_trig),
        .pin_sync(ext_sync)
    );

    scp_arg_collect u_arg (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clr(arg_clr),
        .feed(arg_feed),
        .ch(cur_ch),
        .int_dig(int_dig),
        .frac_dig(frac_dig),
        .dig_cnt(dig_cnt)
    );

    // ==========================================
    // receive buffer and command walk
    always_ff @(posedge clk_sys) begin
        if (state == ST_IDLE && rx_valid && rx_data != CH_EXECUTE && !wr_cnt[BUF_AW]) begin
            cmd_buf[wr_cnt[BUF_AW-1:0]] <= rx_data;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            wr_cnt <= '0;
            rd_ptr <= '0;
            cmd <= 8'h0;
            cmd_pend <= 1'b0;
            next_cmd <= 8'h0;
            next_pend <= 1'b0;
            rx_ready <= 1'b1;
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_sync;
            case (state)
                ST_IDLE: begin
                    if (rx_valid && rx_data == CH_EXECUTE) begin
                        state <= ST_FETCH;
                        rd_ptr <= '0;
                        rx_ready <= 1'b0;
                    end else if (rx_valid && !wr_cnt[BUF_AW]) begin
                        wr_cnt <= wr_cnt + (BUF_AW + 1)'(1);
                    end
                end
                ST_FETCH: begin
                    if (at_end) begin
                        state <= cmd_pend ? ST_APPLY : ST_DONE;
                    end else begin
                        rd_ptr <= rd_ptr + (BUF_AW + 1)'(1);
                        if (is_ltr && cmd_pend) begin
                            next_cmd <= cur_ch;
                            next_pend <= 1'b1;
                            state <= ST_APPLY;
                        end else if (is_ltr) begin
                            cmd <= cur_ch;
                            cmd_pend <= 1'b1;
                        end
                    end
                end
                ST_APPLY: begin
                    cmd <= next_cmd;
                    cmd_pend <= next_pend;
                    next_pend <= 1'b0;
                    state <= next_pend ? ST_FETCH : ST_DONE;
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                    wr_cnt <= '0;
                    cmd_pend <= 1'b0;
                    rx_ready <= 1'b1;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // settings loaded by commands
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            time_bcd <= 24'h0;
            alarm_bcd <= 24'h0;
            date_month <= 8'h0;
            date_day <= 8'h0;
            intv_int <= 12'h0;
            intv_frac <= 12'h0;
            trig_mode <= TRIG_RST;
            prog_mode <= PROG_RST;
            disp_code <= DISP_CHANNEL;
            term_code <= TERM_RST;
        end else if (applying && !apply_err) begin
            case (cmd)
                CH_SET_TIME: time_bcd <= int_dig;
                CH_ALARM: alarm_bcd <= int_dig;
                CH_TRIGGER: trig_mode <= int_dig[2:0];
                CH_PROGRAM: prog_mode <= int_dig[1:0];
                CH_DISPLAY: disp_code <= int_dig[3:0];
                CH_TERM: term_code <= int_dig[3:0];
                CH_INTERVAL: begin
                    intv_int <= int_dig[11:0];
                    intv_frac <= frac_dig;
                end
                CH_DATE: begin
                    if (ctrl_intl) begin
                        date_day <= int_dig[15:8];
                        date_month <= int_dig[7:0];
                    end else begin
                        date_month <= int_dig[15:8];
                        date_day <= int_dig[7:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // digital outputs, octal argument
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dio_out <= 8'h0;
        end else if (dev_clear) begin
            dio_out <= 8'h0;
        end else if (applying && cmd == CH_DIO) begin
            dio_out <= {int_dig[9:8], int_dig[6:4], int_dig[2:0]};
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            illegal_option_error <= 1'b0;
        end else if (apply_err) begin
            illegal_option_error <= 1'b1;
        end else if (stat_clr) begin
            illegal_option_error <= 1'b0;
        end
    end

    // ==========================================
    // channel position and run state
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cur_channel <= FIRST_RST;
            relay_closed <= 1'b0;
            scan_running <= 1'b0;
        end else if (applying && cmd == CH_RESET) begin
            cur_channel <= first_ch;
            relay_closed <= 1'b0;
        end else if (stim) begin
            if (prog_mode == PROG_STEP) begin
                relay_closed <= 1'b1;
                cur_channel <= (cur_channel == last_ch) ? first_ch : cur_channel + 8'h1;
            end else if (!trig_mode[0]) begin
                scan_running <= 1'b1;
                relay_closed <= 1'b1;
            end else begin
                scan_running <= 1'b0;
            end
        end
    end

    // six-digit interval regardless of entry length
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            disp_value <= 24'h0;
        end else begin
            case (disp_code)
                SHOW_INTERVAL_DISPLAY_CODE: disp_value <= {intv_int, intv_frac};
                SHOW_TIME_DISPLAY_CODE: disp_value <= time_bcd;
                default: disp_value <= {16'h0, cur_channel};
            endcase
        end
    end

    // ==========================================
    // register port
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_intl <= 1'b0;
            first_ch <= FIRST_RST;
            last_ch <= LAST_RST;
        end else if (wr_en) begin
            case (addr)
                OFS_CTRL: ctrl_intl <= wdata[CTRL_INTL_BIT];
                OFS_FIRST: first_ch <= wdata[7:0];
                OFS_LAST: last_ch <= wdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 32'h0;
        end else if (rd_en) begin
            case (addr)
                OFS_CTRL: rdata <= {31'h0, ctrl_intl};
                OFS_FIRST: rdata <= {24'h0, first_ch};
                OFS_LAST: rdata <= {24'h0, last_ch};
                OFS_STAT: rdata <= {23'h0, !rx_ready, scan_running, prog_mode,
                                    trig_mode, relay_closed, illegal_option_error};
                OFS_TIME: rdata <= {8'h0, time_bcd};
                OFS_ALARM: rdata <= {8'h0, alarm_bcd};
                OFS_DATE: rdata <= {16'h0, date_month, date_day};
                OFS_INTV: rdata <= {8'h0, intv_int, intv_frac};
                OFS_CHAN: rdata <= {8'h0, term_code, disp_code[3:0], dio_out, cur_channel};
                default: rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence exec_arrives;
        state == ST_IDLE && rx_valid && rx_data == CH_EXECUTE;
    endsequence

    sequence walk_starts;
        state == ST_FETCH && !rx_ready;
    endsequence

    buffered_exec_a: assert property (
        exec_arrives |=> walk_starts
    ) else $error("execute char did not start the command walk");

    hold_until_exec_a: assert property (
        state == ST_IDLE && rx_valid && rx_data != CH_EXECUTE |=> state == ST_IDLE
    ) else $error("command ran before execute char");

    reset_opens_a: assert property (
        applying && cmd == CH_RESET |=> !relay_closed && cur_channel == $past(first_ch)
    ) else $error("reset did not open channels at first channel");

    time_fill_a: assert property (
        applying && cmd == CH_SET_TIME && dig_cnt == 3'h2 |=> time_bcd[23:8] == 16'h0
    ) else $error("short time entry not filled from seconds");

    date_short_a: assert property (
        applying && cmd == CH_DATE && dig_cnt <= 3'h2
        |=> illegal_option_error && $stable(date_month) && $stable(date_day)
    ) else $error("short date entry accepted");

    date_three_a: assert property (
        applying && cmd == CH_DATE && dig_cnt == 3'h3 && !ctrl_intl |=> date_month[7:4] == 4'h0
    ) else $error("three-digit date not right justified");

    trig_range_a: assert property (
        applying && cmd == CH_TRIGGER && int_dig[3:0] > TRIG_MAX
        |=> $stable(trig_mode) && illegal_option_error
    ) else $error("out of range trigger code changed mode");

    step_advance_a: assert property (
        stim && !applying && prog_mode == PROG_STEP && cur_channel != last_ch
        |=> cur_channel == $past(cur_channel) + 8'h1
    ) else $error("step mode did not advance one channel");

    start_keep_a: assert property (
        stim && !applying && prog_mode != PROG_STEP && !trig_mode[0]
        |=> scan_running && $stable(cur_channel)
    ) else $error("start did not resume at current channel");

    disp_intv_a: assert property (
        disp_code == SHOW_INTERVAL_DISPLAY_CODE
        |=> disp_value[23:12] == $past(intv_int) && disp_value[11:0] == $past(intv_frac)
    ) else $error("interval not shown for display code");

    dio_clear_a: assert property (
        dev_clear |=> dio_out == 8'h0
    ) else $error("device clear left digital outputs high");
endmodule

/* tb/scp_host_model.sv */
// bus controller model that sends command strings and bus messages
`timescale 1ns/10ps
module scp_host_model (
    input wire logic clk_sys,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic talk_addr,
    output logic get_msg
);
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        talk_addr = 1'b0;
        get_msg = 1'b0;
    end

    // ========================================
    // character stream, random pacing
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk_sys);
            rx_data <= s[i];
            rx_valid <= 1'b1;
            if ($urandom_range(1) == 1 || i == s.len() - 1) begin
                @(posedge clk_sys);
                rx_valid <= 1'b0;
                rx_data <= ~s[i];
            end
        end
        // execute char ends the string, wait for the command walk
        if (s[s.len() - 1] == "X") begin
            @(posedge clk_sys);
            for (int w = 0; w < 300 && rx_ready !== 1'b1; w++) @(posedge clk_sys);
            repeat (2) @(posedge clk_sys);
        end
        @(negedge clk_sys);
    endtask

    // ========================================
    // talk addressing or group trigger
    task automatic bus_msg(input logic get);
        @(posedge clk_sys);
        talk_addr <= ~get;
        get_msg <= get;
        @(posedge clk_sys);
        talk_addr <= 1'b0;
        get_msg <= 1'b0;
    endtask
endmodule

/* tb/scp_parser_tb.sv */
// self-checking bench for the scanner command parser
`timescale 1ns/10ps
module scp_parser_tb import scp_pkg::*; ;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] rx_data, addr, cur_channel, dio_out;
    logic rx_valid, rx_ready, talk_addr, get_msg, dev_clear, ext_trig, wr_en, rd_en;
    logic [31:0] wdata, rdata;
    logic illegal_option_error, relay_closed, scan_running, rd_seen;
    logic [3:0] disp_code, term_code;
    logic [23:0] disp_value;
    logic [31:0] exp_q[$], msk_q[$];
    string nm_q[$];
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    int hh, mm, ss, v;

    always #2 clk_sys = ~clk_sys;

    scp_parser i_scp_parser (.clk_sys(clk_sys), .arst_n(arst_n), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .talk_addr(talk_addr), .get_msg(get_msg),
        .dev_clear(dev_clear), .ext_trig(ext_trig), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .illegal_option_error(illegal_option_error), .disp_code(disp_code),
        .disp_value(disp_value), .cur_channel(cur_channel), .relay_closed(relay_closed),
        .scan_running(scan_running), .dio_out(dio_out), .term_code(term_code));

    scp_host_model i_scp_host_model (.clk_sys(clk_sys), .rx_ready(rx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid), .talk_addr(talk_addr), .get_msg(get_msg));

    // ========================================
    // checking and bus tasks
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] got);
        check_count++;
        if (got !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, e, got);
        end
    endtask

    task automatic finish_test();
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk_sys) rd_seen <= rd_en;
    always @(negedge clk_sys) begin
        if (rd_seen === 1'b1 && exp_q.size() > 0) begin
            cmp(nm_q.pop_front(), exp_q.pop_front(), rdata & msk_q.pop_front());
        end
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            finish_test();
        end
    end

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input string nm);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        nm_q.push_back(nm);
        @(posedge clk_sys);
        rd_en <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        @(negedge clk_sys);
    endtask

    function automatic logic [7:0] bcd(input int n);
        return 8'((n / 10) * 16 + n % 10);
    endfunction

    // one stimulus of the kind that trigger code k selects
    task automatic stim(input int k);
        case (k / 2)
            0: i_scp_host_model.bus_msg(1'b0);
            1: i_scp_host_model.bus_msg(1'b1);
            2: i_scp_host_model.send("X");
            default: begin
                @(posedge clk_sys);
                ext_trig <= 1'b1;
                repeat (6) @(posedge clk_sys);
                ext_trig <= 1'b0;
            end
        endcase
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // ========================================
    // main sequence
    initial begin
        addr = 8'h00;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        dev_clear = 1'b0;
        ext_trig = 1'b0;
        void'($urandom(32'h7569fa6c));
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(negedge clk_sys);
        cmp("dio reset", 32'h0, 32'(dio_out));
        rd(OFS_FIRST, 32'(FIRST_RST), 32'hff, "first");
        rd(8'h40, 32'h0, 32'hffffffff, "unmapped");
        hh = $urandom_range(23);
        mm = $urandom_range(59);
        ss = $urandom_range(59);
        i_scp_host_model.send($sformatf("S%02d:%02d:%02dX", hh, mm, ss));
        rd(OFS_TIME, {8'h00, bcd(hh), bcd(mm), bcd(ss)}, 32'hffffff, "time");
        i_scp_host_model.send("S1415X");
        rd(OFS_TIME, 32'h001415, 32'hffffff, "short time");
        i_scp_host_model.send("S17X");
        rd(OFS_TIME, 32'h000017, 32'hffffff, "seconds only");
        i_scp_host_model.send("Q17X");
        rd(OFS_ALARM, 32'h000017, 32'hffffff, "short alarm");
        i_scp_host_model.send("V07:12X");
        rd(OFS_DATE, 32'h0712, 32'hffff, "date us");
        wr(OFS_CTRL, 32'h1);
        i_scp_host_model.send("V1207X");
        rd(OFS_DATE, 32'h0712, 32'hffff, "date intl");
        wr(OFS_CTRL, 32'h0);
        i_scp_host_model.send("V123X");
        rd(OFS_DATE, 32'h0123, 32'hffff, "date three");
        i_scp_host_model.send("V12X");
        cmp("error set", 32'h1, 32'(illegal_option_error));
        rd(OFS_DATE, 32'h0123, 32'hffff, "date kept");
        wr(OFS_STAT, 32'h1);
        cmp("error clear", 32'h0, 32'(illegal_option_error));
        i_scp_host_model.send("W003.000X");
        rd(OFS_INTV, 32'h003000, 32'hffffff, "interval");
        i_scp_host_model.send("W.5X");
        rd(OFS_INTV, 32'h000500, 32'hffffff, "interval short");
        i_scp_host_model.send("D1");
        cmp("disp held", 32'(DISP_CHANNEL), 32'(disp_code));
        i_scp_host_model.send("X");
        cmp("disp code", 32'(SHOW_INTERVAL_DISPLAY_CODE), 32'(disp_code));
        cmp("disp value", 32'h000500, 32'(disp_value));
        i_scp_host_model.send("D2D0X");
        cmp("disp order", 32'(DISP_CHANNEL), 32'(disp_code));
        i_scp_host_model.send("P0T2X");
        stim(2);
        stim(2);
        cmp("step channel", 32'h3, 32'(cur_channel));
        cmp("step relay", 32'h1, 32'(relay_closed));
        i_scp_host_model.send("P2X");
        for (int k = 0; k < 8; k++) begin
            i_scp_host_model.send($sformatf("T%0dX", k));
            stim(k);
            cmp("run first", 32'(k % 2 == 0), 32'(scan_running));
            if (k == 0) cmp("resume", 32'h3, 32'(cur_channel));
            stim(k);
            cmp("run again", 32'(k % 2 == 0), 32'(scan_running));
        end
        i_scp_host_model.send("T8X");
        cmp("bad trig", 32'h1, 32'(illegal_option_error));
        rd(OFS_STAT, 32'h1c, 32'h1c, "trig kept");
        wr(OFS_FIRST, 32'h5);
        i_scp_host_model.send("RX");
        cmp("reset channel", 32'h5, 32'(cur_channel));
        cmp("reset relay", 32'h0, 32'(relay_closed));
        i_scp_host_model.send("Y2X");
        cmp("terminator", 32'h2, 32'(term_code));
        v = $urandom_range(255);
        i_scp_host_model.send($sformatf("O%03oX", v));
        cmp("dio set", 32'(v), 32'(dio_out));
        @(posedge clk_sys);
        dev_clear <= 1'b1;
        @(posedge clk_sys);
        dev_clear <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        cmp("dio clear", 32'h0, 32'(dio_out));
        repeat (3) @(posedge clk_sys);
        finish_test();
    end
endmodule
